// >>> verilog/usrb_pkg.sv
// shared constants and carrier types for the unit status register bank
package usrb_pkg;

  // zero-based internal addresses of the unit registers
  localparam logic [15:0] USRB_ADDR_OP_STATUS = 16'h0b54;
  localparam logic [15:0] USRB_ADDR_FAULT_FLAGS = 16'h0b55;
  localparam logic [15:0] USRB_ADDR_FAULT_SUMMARY = 16'h0b56;
  localparam logic [15:0] USRB_ADDR_SERIAL_HIGH = 16'h0b57;
  localparam logic [15:0] USRB_ADDR_SERIAL_LOW = 16'h0b58;
  localparam logic [15:0] USRB_ADDR_CLOCK_MONTH = 16'h0b59;
  localparam logic [15:0] USRB_ADDR_CLOCK_DAY = 16'h0b5a;
  localparam logic [15:0] USRB_ADDR_CLOCK_YEAR = 16'h0b5b;
  localparam logic [15:0] USRB_ADDR_CLOCK_HOURS = 16'h0b5c;
  localparam logic [15:0] USRB_ADDR_CLOCK_MINUTES = 16'h0b5d;
  localparam logic [15:0] USRB_ADDR_CLOCK_SECONDS = 16'h0b5e;
  localparam logic [15:0] USRB_ADDR_CLOCK_SET = 16'h0b65;
  localparam logic [15:0] USRB_ADDR_MAX_SENSORS = 16'h0b69;
  localparam logic [15:0] USRB_ADDR_UNIT_TYPE = 16'h0b6a;
  localparam logic [15:0] USRB_ADDR_FW_VERSION = 16'h0b6b;
  localparam logic [15:0] USRB_ADDR_FW_BUILD = 16'h0b6c;
  localparam logic [15:0] USRB_ADDR_FIRST = USRB_ADDR_OP_STATUS;
  localparam logic [15:0] USRB_ADDR_LAST = USRB_ADDR_FW_BUILD;
  localparam int USRB_NUM_WORDS = 25;

  // read-holding-registers function and exception answers
  localparam logic [7:0] USRB_FUNC_READ_HOLDING = 8'h03;
  localparam logic [7:0] USRB_EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] USRB_EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] USRB_EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] USRB_MAX_QUANTITY = 16'h007d;

  // operating status word layout
  localparam int USRB_OP_RELAY_LSB = 10;
  localparam int USRB_OP_LATCHED_BIT = 14;
  localparam int USRB_OP_BUSY_BIT = 15;

  // fault summary word layout and special values
  localparam logic [15:0] USRB_FS_UNIT_FAULT = 16'hffff;
  localparam int USRB_FS_MISSING_BIT = 15;
  localparam int USRB_FS_MASTER_BIT = 12;
  localparam int USRB_FS_OFF_BIT = 8;
  localparam int USRB_NUM_SENSORS = 8;

  // legal calendar ranges
  localparam logic [15:0] USRB_MONTH_MIN = 16'h0001;
  localparam logic [15:0] USRB_MONTH_MAX = 16'h000c;
  localparam logic [15:0] USRB_DAY_MIN = 16'h0001;
  localparam logic [15:0] USRB_DAY_MAX = 16'h001f;
  localparam logic [15:0] USRB_YEAR_MIN = 16'h07d0;
  localparam logic [15:0] USRB_YEAR_MAX = 16'h0866;
  localparam logic [15:0] USRB_HOURS_MAX = 16'h0017;
  localparam logic [15:0] USRB_MINSEC_MAX = 16'h003b;
  localparam logic [15:0] USRB_ZERO = 16'h0000;

  // reset values of the held calendar
  localparam logic [15:0] USRB_RST_MONTH = 16'h0001;
  localparam logic [15:0] USRB_RST_DAY = 16'h0001;
  localparam logic [15:0] USRB_RST_YEAR = 16'h07d0;

  // live unit activity and relay state
  typedef struct packed {
    logic [9:0] activity;
    logic [3:0] relay_engaged;
    logic relay_latched;
    logic busy;
  } usrb_status_t;

  // fault sources feeding the two reason words
  typedef struct packed {
    logic [7:0] sensor_fault;
    logic [7:0][7:0] error_code;
    logic unit_fault;
    logic sensor_missing;
    logic master_control;
    logic master_forced_off;
  } usrb_fault_t;

  // real-time-clock fields from the clock keeper
  typedef struct packed {
    logic [15:0] month;
    logic [15:0] day;
    logic [15:0] year;
    logic [15:0] hours;
    logic [15:0] minutes;
    logic [15:0] seconds;
    logic set_pending;
  } usrb_clock_t;

  // identification values
  typedef struct packed {
    logic [31:0] serial;
    logic [7:0] fw_major;
    logic [7:0] fw_minor;
    logic [15:0] fw_build;
  } usrb_ident_t;

  // decoded request from the protocol engine
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] quantity;
  } usrb_req_t;

  // one answer word or an exception
  typedef struct packed {
    logic [15:0] data;
    logic last;
    logic exception;
    logic [7:0] exc_code;
  } usrb_rsp_t;

endpackage

// >>> verilog/usrb_fault_summary.sv
// fault summary word encoder with fault source priority
`timescale 1ns/1ns
module usrb_fault_summary
  import usrb_pkg::*;
(
  input wire usrb_fault_t fault,
  output logic [15:0] word
);

  // highest faulting sensor code, then overriding conditions
  always_comb
  begin
    word = USRB_ZERO;
    for (int i = 0; i < USRB_NUM_SENSORS; i++)
    begin
      if (fault.sensor_fault[i])
      begin
        word = {8'h00, fault.error_code[i]};
      end
    end
    if (fault.master_control)
    begin
      word = USRB_ZERO;
      word[USRB_FS_MASTER_BIT] = 1'b1;
      word[USRB_FS_OFF_BIT] = fault.master_forced_off;
    end
    if (fault.sensor_missing)
    begin
      word = USRB_ZERO;
      word[USRB_FS_MISSING_BIT] = 1'b1;
    end
    if (fault.unit_fault)
    begin
      word = USRB_FS_UNIT_FAULT;
    end
  end

endmodule

// >>> verilog/usrb_bank.sv
// unit status register bank answering read-holding-register requests
//
// How it works
// - status bits 0-9 flag unit activities
// - bits 10-13 show engaged relays
// - bit 14 set when any relay latched
// - bit 15 set while unit busy
// - flag word bit n-1 for sensor n
// - flag word bits 8-15 read zero
// - summary low byte: highest faulting sensor code
// - unit fault makes summary all ones
// - missing sensor shows bit 15 alone
// - master control: bit 12, bit 8 off
// - summary bits 9-11,13,14 read zero unless unit fault
// - serial high word first, low next
// - month 1-12, day 1-31
// - year held within 2000-2150
// - hours 0-23, minutes/seconds 0-59
// - clock set word reads pending flag
// - register reports maximum sensor count
// - register reports unit type code
// - firmware word: major high, minor low
// - firmware word two: build number
// - read-holding function answered with contents
// - request addresses are zero-based internal
`timescale 1ns/1ns
module usrb_bank
  import usrb_pkg::*;
#(
  // arbitrary neutral value, set per product variant
  parameter logic [15:0] UNIT_TYPE = 16'h0abc,
  // channel capacity of this build
  parameter logic [15:0] MAX_SENSORS = 16'h0008
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire usrb_status_t status_in,
  input wire usrb_fault_t fault_in,
  input wire usrb_clock_t clock_in,
  input wire usrb_ident_t ident_in,
  input wire logic req_valid,
  input wire usrb_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output usrb_rsp_t rsp
);

  // idle takes requests, send streams one word per cycle
  typedef enum {
    USRB_IDLE,
    USRB_SEND
  } usrb_state_t;

  // true when lo <= v <= hi
  function automatic logic in_range(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // word index inside the unit block
  // addresses below the block wrap high; they are refused before use
  function automatic logic [4:0] word_index(input logic [15:0] addr);
    logic [15:0] diff;
    diff = addr - USRB_ADDR_FIRST;
    word_index = diff[4:0];
  endfunction

  usrb_state_t state; // transfer sequencer
  logic [15:0] op_status; // registered operating status
  logic [15:0] fault_flags; // registered per-sensor flags
  logic [15:0] fault_summary; // registered coded summary
  logic [15:0] next_summary; // encoder output
  logic [15:0] month; // validated calendar fields
  logic [15:0] day;
  logic [15:0] year;
  logic [15:0] hours;
  logic [15:0] minutes;
  logic [15:0] seconds;
  logic set_pending; // clock set pending copy
  logic [15:0] live [USRB_NUM_WORDS]; // current register image
  logic [15:0] snap [USRB_NUM_WORDS]; // image frozen per request
  logic [4:0] cur; // word being sent
  logic [15:0] remaining; // words still to send
  logic accept; // request taken this edge
  logic [16:0] end_addr; // last address asked for
  logic [7:0] next_exc; // exception verdict, zero when fine

  // coded fault summary with its priority order
  usrb_fault_summary u_summary (
    .fault(fault_in),
    .word(next_summary)
  );

  // operating status word from live activity inputs
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_status <= USRB_ZERO;
    end
    else
    begin
      op_status[9:0] <= status_in.activity;
      op_status[USRB_OP_RELAY_LSB +: 4] <= status_in.relay_engaged;
      op_status[USRB_OP_LATCHED_BIT] <= status_in.relay_latched;
      op_status[USRB_OP_BUSY_BIT] <= status_in.busy;
    end
  end

  // both fault reason words
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fault_flags <= USRB_ZERO;
      fault_summary <= USRB_ZERO;
    end
    else
    begin
      fault_flags <= {8'h00, fault_in.sensor_fault};
      // undefined bits left zero by encoder, all ones on unit fault
      fault_summary <= next_summary;
    end
  end

  // calendar fields; an out-of-range sample keeps the last good value
  // so the master never sees an impossible date mid-update
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      month <= USRB_RST_MONTH;
      day <= USRB_RST_DAY;
      year <= USRB_RST_YEAR;
      hours <= USRB_ZERO;
      minutes <= USRB_ZERO;
      seconds <= USRB_ZERO;
    end
    else
    begin
      if (in_range(clock_in.month, USRB_MONTH_MIN, USRB_MONTH_MAX))
      begin
        month <= clock_in.month;
      end
      if (in_range(clock_in.day, USRB_DAY_MIN, USRB_DAY_MAX))
      begin
        day <= clock_in.day;
      end
      if (in_range(clock_in.year, USRB_YEAR_MIN, USRB_YEAR_MAX))
      begin
        year <= clock_in.year;
      end
      if (in_range(clock_in.hours, USRB_ZERO, USRB_HOURS_MAX))
      begin
        hours <= clock_in.hours;
      end
      if (in_range(clock_in.minutes, USRB_ZERO, USRB_MINSEC_MAX))
      begin
        minutes <= clock_in.minutes;
      end
      if (in_range(clock_in.seconds, USRB_ZERO, USRB_MINSEC_MAX))
      begin
        seconds <= clock_in.seconds;
      end
    end
  end

  // clock set pending flag
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      set_pending <= 1'b0;
    end
    else
    begin
      set_pending <= clock_in.set_pending;
    end
  end

  // register image by word index
  always_comb
  begin
    for (int i = 0; i < USRB_NUM_WORDS; i++)
    begin
      live[i] = USRB_ZERO;
    end
    live[word_index(USRB_ADDR_OP_STATUS)] = op_status;
    live[word_index(USRB_ADDR_FAULT_FLAGS)] = fault_flags;
    live[word_index(USRB_ADDR_FAULT_SUMMARY)] = fault_summary;
    // serial high half at lower address
    live[word_index(USRB_ADDR_SERIAL_HIGH)] = ident_in.serial[31:16];
    live[word_index(USRB_ADDR_SERIAL_LOW)] = ident_in.serial[15:0];
    live[word_index(USRB_ADDR_CLOCK_MONTH)] = month;
    live[word_index(USRB_ADDR_CLOCK_DAY)] = day;
    live[word_index(USRB_ADDR_CLOCK_YEAR)] = year;
    live[word_index(USRB_ADDR_CLOCK_HOURS)] = hours;
    live[word_index(USRB_ADDR_CLOCK_MINUTES)] = minutes;
    live[word_index(USRB_ADDR_CLOCK_SECONDS)] = seconds;
    live[word_index(USRB_ADDR_CLOCK_SET)] = {15'h0000, set_pending};
    live[word_index(USRB_ADDR_MAX_SENSORS)] = MAX_SENSORS;
    live[word_index(USRB_ADDR_UNIT_TYPE)] = UNIT_TYPE;
    live[word_index(USRB_ADDR_FW_VERSION)] =
      {ident_in.fw_major, ident_in.fw_minor};
    live[word_index(USRB_ADDR_FW_BUILD)] = ident_in.fw_build;
  end

  // handshake: only taken while no transfer is running
  assign req_ready = (state == USRB_IDLE);
  assign accept = req_valid && req_ready;
  assign end_addr = {1'b0, req.addr} + {1'b0, req.quantity} - 17'h0_0001;

  // request check; write functions fall to illegal function
  always_comb
  begin
    next_exc = 8'h00;
    if (req.func != USRB_FUNC_READ_HOLDING)
    begin
      next_exc = USRB_EXC_ILLEGAL_FUNC;
    end
    else if ((req.quantity == USRB_ZERO) ||
             (req.quantity > USRB_MAX_QUANTITY))
    begin
      next_exc = USRB_EXC_ILLEGAL_VALUE;
    end
    else if ((req.addr < USRB_ADDR_FIRST) ||
             (end_addr > {1'b0, USRB_ADDR_LAST}))
    begin
      next_exc = USRB_EXC_ILLEGAL_ADDR;
    end
  end

  // snapshot keeps multi-word reads coherent, e.g. both serial halves
  always_ff @(posedge clk)
  begin
    if (accept)
    begin
      for (int i = 0; i < USRB_NUM_WORDS; i++)
      begin
        snap[i] <= live[i];
      end
    end
  end

  // transfer sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= USRB_IDLE;
      cur <= 5'h00;
      remaining <= USRB_ZERO;
    end
    else
    begin
      case (state)
        USRB_IDLE:
        begin
          // good request starts streaming next cycle
          if (accept && (next_exc == 8'h00))
          begin
            state <= USRB_SEND;
            cur <= word_index(req.addr);
            remaining <= req.quantity;
          end
        end
        USRB_SEND:
        begin
          cur <= cur + 5'h01;
          remaining <= remaining - 16'h0001;
          if (remaining == 16'h0001)
          begin
            state <= USRB_IDLE;
          end
        end
        default:
        begin
          state <= USRB_IDLE;
        end
      endcase
    end
  end

  // answer port: one word per cycle, or a single exception
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else if (state == USRB_SEND)
    begin
      rsp_valid <= 1'b1;
      rsp.data <= snap[cur];
      rsp.last <= (remaining == 16'h0001);
      rsp.exception <= 1'b0;
      rsp.exc_code <= 8'h00;
    end
    else if (accept && (next_exc != 8'h00))
    begin
      rsp_valid <= 1'b1;
      rsp.data <= USRB_ZERO;
      rsp.last <= 1'b1;
      rsp.exception <= 1'b1;
      rsp.exc_code <= next_exc;
    end
    else
    begin
      // data left as is; only rsp_valid qualifies it
      rsp_valid <= 1'b0;
      rsp.last <= 1'b0;
      rsp.exception <= 1'b0;
    end
  end

endmodule

// >>> dv/usrb_sva.sv
// bound checker for the unit status register bank ports
`timescale 1ns/1ns
module usrb_sva
  import usrb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire usrb_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire usrb_rsp_t rsp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take; // request taken at this edge
  logic rd; // read function asked for
  logic qok; // quantity within limits
  logic good; // fully legal read
  logic [15:0] cur; // address of the word on show
  assign take = req_valid && req_ready;
  assign rd = req.func == USRB_FUNC_READ_HOLDING;
  assign qok = req.quantity != 16'h0000 && req.quantity <= USRB_MAX_QUANTITY;
  // 17-bit sum so a huge start address cannot wrap into range
  assign good = take && rd && qok && req.addr >= USRB_ADDR_FIRST
    && 17'(req.addr) + 17'(req.quantity) <= 17'(USRB_ADDR_LAST) + 17'h1;
  // word address tracker, restarted by every taken request
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      cur <= 16'h0000;
    else if (take)
      cur <= req.addr;
    else if (rsp_valid)
      cur <= cur + 16'h0001;
  sequence s_exc(logic [7:0] c);
    rsp_valid && rsp.exception && rsp.last && rsp.exc_code == c;
  endsequence
  sequence s_at(logic [15:0] a);
    rsp_valid && !rsp.exception && cur == a;
  endsequence
  a_func_refused: assert property (take && !rd |=>
    s_exc(USRB_EXC_ILLEGAL_FUNC)) else $error("bad function not refused");
  a_qty_refused: assert property (take && rd && !qok
    && req.addr >= USRB_ADDR_FIRST && req.addr <= USRB_ADDR_LAST
    |=> s_exc(USRB_EXC_ILLEGAL_VALUE)) else $error("bad quantity kept");
  a_addr_refused: assert property (take && rd && qok && !good
    |=> s_exc(USRB_EXC_ILLEGAL_ADDR)) else $error("bad address kept");
  a_read_latency: assert property (good |=>
    !rsp_valid && !req_ready ##1 rsp_valid && !rsp.exception)
    else $error("first word late or missing");
  a_single_last: assert property (good && req.quantity == 16'h0001
    |=> ##1 rsp_valid && rsp.last) else $error("single word not last");
  a_stream_busy: assert property (rsp_valid && !rsp.last
    |-> !req_ready) else $error("ready while streaming");
  a_gap_zero: assert property (rsp_valid && !rsp.exception
    && ((cur > USRB_ADDR_CLOCK_SECONDS && cur < USRB_ADDR_CLOCK_SET)
    || (cur > USRB_ADDR_CLOCK_SET && cur < USRB_ADDR_MAX_SENSORS))
    |-> rsp.data == USRB_ZERO) else $error("gap word not zero");
  a_flags_high: assert property (s_at(USRB_ADDR_FAULT_FLAGS)
    |-> rsp.data[15:8] == 8'h00) else $error("flag word high byte set");
  a_summary_zero: assert property (s_at(USRB_ADDR_FAULT_SUMMARY)
    |-> rsp.data == USRB_FS_UNIT_FAULT
    || (rsp.data[14:13] == 2'h0 && rsp.data[11:9] == 3'h0))
    else $error("undefined summary bits set");
  a_month_range: assert property (s_at(USRB_ADDR_CLOCK_MONTH)
    |-> rsp.data inside {[USRB_MONTH_MIN:USRB_MONTH_MAX]})
    else $error("month out of range");
  a_pending_bit: assert property (s_at(USRB_ADDR_CLOCK_SET)
    |-> rsp.data[15:1] == 15'h0) else $error("set status wide");
endmodule
bind usrb_bank usrb_sva u_sva (.clk(clk), .resetn(resetn),
  .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp));

// >>> dv/usrb_master.sv
// polling master stand-in issuing read-holding-register requests
`timescale 1ns/1ns
module usrb_master
  import usrb_pkg::*;
(
  input wire logic clk,
  output logic req_valid,
  output usrb_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire usrb_rsp_t rsp
);
  logic [15:0] words [$]; // data words of the last answer
  logic [7:0] code; // exception code, zero when none
  logic hung; // some bounded wait ran out
  initial
  begin
    req_valid = 1'b0;
    req = '0;
    code = 8'h00;
    hung = 1'b0;
  end
  // one request after gap idle cycles; entered at a falling edge
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] q, input int gap);
    int m;
    int n;
    words.delete();
    code = 8'h00;
    repeat (gap) @(negedge clk);
    req_valid = 1'b1;
    req = '{func: f, addr: a, quantity: q};
    for (m = 0; m < 50 && !req_ready; m++)
      @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    // released lines show the inverse, not the stale request
    req = usrb_req_t'(~req);
    for (n = 0; n < 200; n++)
    begin
      if (rsp_valid && !rsp.exception)
        words.push_back(rsp.data);
      if (rsp_valid && rsp.exception)
        code = rsp.exc_code;
      if (rsp_valid && rsp.last)
        break;
      @(negedge clk);
    end
    hung = hung | (n == 200) | (m == 50);
    // keeps two drives of req out of one time step
    if (n == 0)
      @(negedge clk);
  endtask
endmodule

// >>> dv/usrb_bank_tb.sv
// self-checking bench for the unit status register bank
`timescale 1ns/1ns
module usrb_bank_tb
  import usrb_pkg::*;
  ;
  localparam logic [15:0] TB_TYPE = 16'h0c3d; // arbitrary type code
  localparam logic [15:0] TB_MAX = 16'h0002; // two-channel build
  logic clk;
  logic resetn;
  usrb_status_t status_in;
  usrb_fault_t fault_in;
  usrb_clock_t clock_in;
  usrb_ident_t ident_in;
  logic req_valid;
  usrb_req_t req;
  logic req_ready;
  logic rsp_valid;
  usrb_rsp_t rsp;
  int mismatches = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  usrb_bank #(.UNIT_TYPE(TB_TYPE), .MAX_SENSORS(TB_MAX)) dut (.clk(clk),
    .resetn(resetn), .status_in(status_in), .fault_in(fault_in),
    .clock_in(clock_in), .ident_in(ident_in), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));
  usrb_master u_master (.clk(clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp));
  task automatic finish_test();
    $display("counts: %0d compared, %0d mismatched", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request; a hung handshake ends the run
  task automatic go(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] q, input int gap);
    u_master.xfer(f, a, q, gap);
    if (u_master.hung)
    begin
      mismatches++;
      finish_test();
    end
  endtask
  // read with two idle cycles so inputs reach the snapshot
  task automatic rd(input logic [15:0] a, input logic [15:0] q);
    go(USRB_FUNC_READ_HOLDING, a, q, 2);
    chk(16'(u_master.words.size()), q);
  endtask
  // reset for 12 cycles, then a read taken at the first edge after release
  task automatic t_reset();
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    go(USRB_FUNC_READ_HOLDING, USRB_ADDR_CLOCK_MONTH, 16'h0003, 0);
    chk(u_master.words[0], USRB_RST_MONTH);
    chk(u_master.words[1], USRB_RST_DAY);
    chk(u_master.words[2], USRB_RST_YEAR);
    $display("reset snapshot done");
  endtask
  task automatic t_status();
    for (int i = 0; i < 16; i++)
    begin
      status_in = '0;
      if (i < 10) status_in.activity[i] = 1'b1;
      else if (i < 14) status_in.relay_engaged[i-10] = 1'b1;
      else if (i == 14) status_in.relay_latched = 1'b1;
      else status_in.busy = 1'b1;
      rd(USRB_ADDR_OP_STATUS, 16'h0001);
      chk(u_master.words[0], 16'h0001 << i);
    end
    $display("status walk done");
  endtask
  task automatic t_fault();
    logic [15:0] es [6] = '{16'h0017, 16'h0012, 16'h1000, 16'h1100,
      16'h8000, 16'hffff};
    for (int k = 0; k < 6; k++)
    begin
      fault_in = '0;
      for (int i = 0; i < 8; i++) fault_in.error_code[i] = 8'h10 + 8'(i);
      fault_in.sensor_fault = k == 0 ? 8'h81 : k == 1 ? 8'h06 : 8'h00;
      fault_in.master_control = k == 2 || k == 3;
      fault_in.master_forced_off = k == 3;
      fault_in.sensor_missing = k == 4;
      fault_in.unit_fault = k == 5;
      rd(USRB_ADDR_FAULT_FLAGS, 16'h0002);
      chk(u_master.words[0], {8'h00, fault_in.sensor_fault});
      chk(u_master.words[1], es[k]);
    end
    $display("fault words done");
  endtask
  task automatic t_clock();
    logic [15:0] ec [6] = '{16'h000c, 16'h001f, 16'h0866, 16'h0017,
      16'h003b, 16'h003b};
    clock_in = '{16'h000c, 16'h001f, 16'h0866, 16'h0017, 16'h003b,
      16'h003b, 1'b1};
    rd(USRB_ADDR_CLOCK_MONTH, 16'h000d);
    for (int i = 0; i < 6; i++)
      chk(u_master.words[i], ec[i]);
    for (int i = 6; i < 12; i++) chk(u_master.words[i], USRB_ZERO);
    chk(u_master.words[12], 16'h0001);
    // month out of range is ignored, pending dropped
    clock_in.month = 16'h000d;
    clock_in.set_pending = 1'b0;
    rd(USRB_ADDR_CLOCK_MONTH, 16'h000d);
    chk(u_master.words[0], 16'h000c);
    chk(u_master.words[12], USRB_ZERO);
    $display("clock fields done");
  endtask
  task automatic t_ident();
    ident_in = '{32'h1234_5678, 8'h02, 8'h0f, 16'hbeef};
    rd(USRB_ADDR_SERIAL_HIGH, 16'h0002);
    chk(u_master.words[0], 16'h1234);
    chk(u_master.words[1], 16'h5678);
    rd(USRB_ADDR_MAX_SENSORS, 16'h0004);
    chk(u_master.words[0], TB_MAX);
    chk(u_master.words[1], TB_TYPE);
    chk(u_master.words[2], 16'h020f);
    chk(u_master.words[3], 16'hbeef);
    $display("identity done");
  endtask
  task automatic t_errors();
    logic [7:0] fn [6] = '{8'h06, 8'h10, 8'h03, 8'h03, 8'h03, 8'h03};
    logic [15:0] ad [6] = '{16'h0b54, 16'h0b54, 16'h0b54, 16'h0b54,
      16'h0b53, 16'h0b6c};
    logic [15:0] qt [6] = '{16'h0001, 16'h0001, 16'h0000, 16'h007e,
      16'h0001, 16'h0002};
    logic [7:0] ex [6] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h02, 8'h02};
    for (int k = 0; k < 6; k++)
    begin
      go(fn[k], ad[k], qt[k], 0);
      chk({8'h00, u_master.code}, {8'h00, ex[k]});
    end
    // whole area, then a second read taken in the last word cycle
    go(USRB_FUNC_READ_HOLDING, USRB_ADDR_FIRST, 16'(USRB_NUM_WORDS), 0);
    chk(16'(u_master.words.size()), 16'(USRB_NUM_WORDS));
    go(USRB_FUNC_READ_HOLDING, USRB_ADDR_FW_BUILD, 16'h0001, 0);
    chk(u_master.words[0], 16'hbeef);
    $display("refusals done");
  endtask
  initial
  begin
    clk = 1'b0;
    status_in = '0;
    fault_in = '0;
    clock_in = '0;
    ident_in = '0;
    t_reset();
    t_status();
    t_fault();
    t_clock();
    // mid-run reset: calendar must fall back to its reset values
    t_reset();
    t_ident();
    t_errors();
    finish_test();
  end
endmodule
